// file: verif/host_model.sv
`timescale 1ns/1ps

module host_model
(
  // Clock
  input wire logic       clk,
  // Request bus
  output logic           setupValid,
  input wire logic       setupReady,
  output logic [7:0]     setupType,
  output logic [7:0]     setupCode,
  output logic [15:0]    setupValue,
  output logic [15:0]    setupLength,
  output logic           outValid,
  input wire logic       outReady,
  output logic [7:0]     outData,
  input wire logic       inValid,
  input wire logic [7:0] inData,
  input wire logic       reqDone,
  input wire logic       reqStall,
  // Flash store
  input wire logic       flashReq,
  output logic           flashAck,
  output logic [7:0]     flashData
);
  logic [7:0] flashVer = 8'h3c;
  int         flashWait = 1;
  logic       rDone;
  logic       rStall;
  logic [7:0] rData;

  initial
    {setupValid, setupType, setupCode, setupValue, setupLength, outValid, outData, flashAck} = '0;
  initial
    flashData = 8'hc3;

  // Flash answers late; line scrambled between answers
  always @(posedge clk)
  begin
    if (flashReq)
    begin
      repeat (flashWait) @(posedge clk);
      #1 flashAck = 1'b1;
      flashData = flashVer;
      @(posedge clk) #1 flashAck = 1'b0;
      flashData = ~flashVer;
    end
  end

  task automatic req(input logic [7:0] t, c, input logic [15:0] v, l, input logic [7:0] b);
    int n;
    {setupType, setupCode, setupValue, setupLength, outData} = {t, c, v, l, b};
    setupValid = 1'b1;
    while (!setupReady)
      @(posedge clk) #1;
    @(posedge clk) #1 setupValid = 1'b0;
    n = 0;
    while (!reqDone && !reqStall && n < 60)
    begin
      outValid = outReady;
      @(posedge clk) #1;
      if (inValid)
        rData = inData;
      n++;
    end
    outValid = 1'b0;
    rDone = reqDone;
    rStall = reqStall;
  endtask
endmodule

// file: verif/test_usb_vendor_request_decoder.sv
`timescale 1ns/1ps
`include "usb_vendor_regs.vh"

module test_usb_vendor_request_decoder;
  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  logic                 bulkValid = 1'b0;
  logic [7:0]           bulkData = 8'h00;
  logic [`NUM_FPGA-1:0] configDone = '0;
  logic                 setupValid, setupReady, outValid, outReady, inValid, reqDone, reqStall;
  logic                 flashReq, flashAck, mediaLoadStart, regWrite, cfgStrobe, mainBusStrobe;
  logic [7:0]           setupType, setupCode, outData, inData, flashData, regData;
  logic [7:0]           mainBusDisable, cfgData, mainBusData;
  logic [15:0]          setupValue, setupLength, flashAddr, regAddr, readLength;
  logic [`NUM_FPGA-1:0] progN, selected;
  int                   mismatches = 0;
  int                   checksDone = 0;
  int                   loads = 0;
  int                   writes = 0;

  // Arbitrary identification values
  usb_vendor_request_decoder #(.FW_REVISION(8'h5a), .BOARD_TYPE(8'h96)) dut_u
  (
    .clk(clk), .reset(reset), .setupValid(setupValid), .setupReady(setupReady), .setupType(setupType),
    .setupCode(setupCode), .setupValue(setupValue), .setupLength(setupLength), .outValid(outValid),
    .outReady(outReady), .outData(outData), .inValid(inValid), .inData(inData), .reqDone(reqDone),
    .reqStall(reqStall), .flashReq(flashReq), .flashAddr(flashAddr), .flashAck(flashAck), .flashData(flashData),
    .mediaLoadStart(mediaLoadStart), .regWrite(regWrite), .regAddr(regAddr), .regData(regData),
    .mainBusDisable(mainBusDisable), .bulkValid(bulkValid), .bulkData(bulkData), .cfgStrobe(cfgStrobe),
    .cfgData(cfgData), .mainBusStrobe(mainBusStrobe), .mainBusData(mainBusData), .readLength(readLength),
    .configDone(configDone), .progN(progN), .selected(selected)
  );
  host_model host_u
  (
    .clk(clk), .setupValid(setupValid), .setupReady(setupReady), .setupType(setupType), .setupCode(setupCode),
    .setupValue(setupValue), .setupLength(setupLength), .outValid(outValid), .outReady(outReady),
    .outData(outData), .inValid(inValid), .inData(inData), .reqDone(reqDone), .reqStall(reqStall),
    .flashReq(flashReq), .flashAck(flashAck), .flashData(flashData)
  );

  always #25 clk = ~clk;

  always @(posedge clk)
    if (mediaLoadStart)
      loads++;

  always @(posedge clk)
    if (regWrite)
      writes++;

  task automatic check(input string what, input logic [47:0] seen, exp);
    checksDone++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bulk(input logic [7:0] b);
    bulkValid = 1'b1;
    bulkData = b;
    @(posedge clk) #1 bulkValid = 1'b0;
  endtask

  task automatic queries;
    check("progN", progN, 16'hffff);
    check("readLength", readLength, 16'h0000);
    host_u.req(8'hc0, 8'ha6, 16'h0000, 16'h0001, 8'h00);
    check("fwRevision", host_u.rData, 8'h5a);
    host_u.req(8'hc0, 8'hb9, 16'h0000, 16'h0001, 8'h00);
    check("boardType", host_u.rData, 8'h96);
    for (int w = 0; w < 6; w += 5)
    begin
      host_u.flashWait = w;
      host_u.req(8'hc0, 8'hb2, 16'h0000, 16'h0001, 8'h00);
      check("flashVersion", {host_u.rDone, host_u.rData}, {1'b1, host_u.flashVer});
    end
  endtask

  task automatic selection;
    host_u.req(8'h40, 8'hb7, 16'h0000, 16'h0001, 8'h03);
    check("selected", selected, 16'h0008);
    check("eraseOnSelect", progN, 16'hfff7);
    bulk(8'ha5);
    check("cfgByte", {cfgStrobe, mainBusStrobe, cfgData}, {2'b10, 8'ha5});
    configDone = 16'hfff7;
    host_u.req(8'hc0, 8'hb5, 16'h0000, 16'h0001, 8'h00);
    check("blank", host_u.rData, 8'h4e);
    configDone = 16'h0008;
    host_u.req(8'hc0, 8'hb5, 16'h0000, 16'h0001, 8'h00);
    check("configured", host_u.rData, 8'h59);
    host_u.req(8'h40, 8'h90, 16'h000f, 16'h0000, 8'h00);
    check("eraseTop", {progN[15], host_u.rDone}, 2'b01);
    check("keepSelect", selected, 16'h0008);
    host_u.req(8'hc0, 8'hbd, 16'h0000, 16'h0001, 8'h00);
    check("doneBit", {host_u.rDone, host_u.rData}, 9'h101);
    check("released", selected, 16'h0000);
  endtask

  task automatic registers;
    host_u.req(8'h40, 8'hbe, 16'hdf39, 16'h0001, 8'h01);
    check("regAddr", {regAddr, regData}, 24'hdf3901);
    check("disable", mainBusDisable, 8'h01);
    bulk(8'h66);
    check("blocked", mainBusStrobe, 1'b0);
    host_u.req(8'h40, 8'hbe, 16'hdf39, 16'h0001, 8'h00);
    bulk(8'h99);
    check("mainBus", {mainBusStrobe, mainBusData}, 9'h199);
    host_u.req(8'h40, 8'hbb, 16'hffff, 16'h0000, 8'h00);
    check("readLength", readLength, 16'hffff);
    host_u.req(8'h40, 8'hbe, 16'hdf00, 16'h0001, 8'h5a);
    check("otherReg", {regAddr, mainBusDisable}, 24'hdf0000);
    check("regByte", regData, 8'h5a);
    check("writes", writes, 3);
    host_u.req(8'h40, 8'hbd, 16'h0000, 16'h0000, 8'h00);
    check("releaseOut", {host_u.rDone, host_u.rStall}, 2'b10);
    host_u.req(8'h40, 8'haf, 16'h0000, 16'h0000, 8'h00);
    check("mediaLoad", {host_u.rDone, 15'(loads)}, 16'h8001);
  endtask

  task automatic refusals;
    logic [47:0] tbl [7] = '{48'hc0a6_0000_0000, 48'h80b9_0000_0001, 48'h40a7_0000_0000,
      48'h40bb_0123_0001, 48'h4090_0010_0000, 48'h40b7_0000_0000, 48'h40b7_0000_0001};
    foreach (tbl[i])
    begin
      host_u.req(tbl[i][47:40], tbl[i][39:32], tbl[i][31:16], tbl[i][15:0], 8'h10);
      check("refused", {host_u.rStall, host_u.rDone}, 2'b10);
    end
    check("keepState", {readLength ^ 16'hffff, progN ^ 16'hffff, selected}, 48'h0);
  endtask

  task automatic finishTest;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    queries();
    selection();
    registers();
    refusals();
    finishTest();
  end

  initial
  begin
    #(50 * 3000);
    mismatches++;
    finishTest();
  end
endmodule

bind usb_vendor_request_decoder usb_vendor_checker chk_u
(
  .clk(clk), .reset(reset), .setupValid(setupValid), .setupReady(setupReady), .setupType(setupType),
  .setupCode(setupCode), .setupValue(setupValue), .setupLength(setupLength), .reqDone(reqDone),
  .reqStall(reqStall), .mediaLoadStart(mediaLoadStart), .flashReq(flashReq), .flashAddr(flashAddr),
  .bulkValid(bulkValid), .bulkData(bulkData), .cfgStrobe(cfgStrobe), .cfgData(cfgData),
  .mainBusStrobe(mainBusStrobe), .mainBusData(mainBusData), .mainBusDisable(mainBusDisable),
  .readLength(readLength), .progN(progN), .selected(selected)
);

// file: verif/usb_vendor_checker_assertions.sv
`timescale 1ns/1ps
`include "usb_vendor_regs.vh"

module usb_vendor_checker
(
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 reset,
  // Requests
  input wire logic                 setupValid,
  input wire logic                 setupReady,
  input wire logic [7:0]           setupType,
  input wire logic [7:0]           setupCode,
  input wire logic [15:0]          setupValue,
  input wire logic [15:0]          setupLength,
  input wire logic                 reqDone,
  input wire logic                 reqStall,
  input wire logic                 mediaLoadStart,
  input wire logic                 flashReq,
  input wire logic [15:0]          flashAddr,
  // Data paths
  input wire logic                 bulkValid,
  input wire logic [7:0]           bulkData,
  input wire logic                 cfgStrobe,
  input wire logic [7:0]           cfgData,
  input wire logic                 mainBusStrobe,
  input wire logic [7:0]           mainBusData,
  input wire logic [7:0]           mainBusDisable,
  input wire logic [15:0]          readLength,
  input wire logic [`NUM_FPGA-1:0] progN,
  input wire logic [`NUM_FPGA-1:0] selected
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  wire idle = ~|selected;

  sequence take(c);
    setupValid && setupReady && setupCode == c && setupType[6:5] == `TYPE_KIND_VENDOR;
  endsequence
  sequence lengthTake;
    take(`CODE_READ_LENGTH) ##0 !setupType[7] && setupLength == 16'h0000;
  endsequence
  sequence unknownTake;
    setupValid && setupReady
      && !(setupCode inside {8'h90, 8'ha6, 8'haf, 8'hb2, 8'hb5, 8'hb7, 8'hb9, 8'hbb, 8'hbd, 8'hbe});
  endsequence

  a_read_length: assert property (lengthTake |-> ##2 reqDone && readLength == $past(setupValue, 2))
    else $error("read length not latched");
  a_unknown_stall: assert property (unknownTake |-> ##2 reqStall && !reqDone && $stable(selected))
    else $error("unknown code not refused");
  a_release_all: assert property (take(`CODE_TARGET_RELEASE) |-> ##2 selected == 0)
    else $error("selection kept after release");
  a_media_start: assert property (take(`CODE_MEDIA_LOAD) |-> ##[1:2] mediaLoadStart)
    else $error("media load not started");
  a_flash_addr: assert property (flashReq |-> flashAddr == {`FLASH_VER_UPPER, `FLASH_VER_LOWER})
    else $error("flash address wrong");
  a_select_erase: assert property (selected != 0 && $changed(selected) |-> ((progN & selected) == 0) [*8])
    else $error("selected device not erased");
  a_one_hot: assert property ($onehot0(selected))
    else $error("selection not one-hot");
  a_bulk_config: assert property (bulkValid && !idle |=> cfgStrobe && cfgData == $past(bulkData))
    else $error("bulk byte not sent to config");
  a_bulk_mainbus: assert property (bulkValid && idle && !mainBusDisable[0] |=> mainBusStrobe
    && mainBusData == $past(bulkData))
    else $error("bulk byte not sent to main bus");
  a_bus_blocked: assert property (bulkValid && idle && mainBusDisable[0] |=> !mainBusStrobe)
    else $error("main bus not blocked");
endmodule

// file: verilog/fpga_channel_ctrl.v
`timescale 1ns/1ps
`include "usb_vendor_regs.vh"

module fpga_channel_ctrl
(
  // Clock and reset
  input  wire                   clk,
  input  wire                   reset,
  // Commands
  input  wire                   eraseStrobe,
  input  wire [`FPGA_IDX_W-1:0] eraseIndex,
  input  wire                   selectStrobe,
  input  wire [`FPGA_IDX_W-1:0] selectIndex,
  input  wire                   releaseAll,
  // Device status
  input  wire [`NUM_FPGA-1:0]   configDone,
  // Device control
  output wire [`NUM_FPGA-1:0]   progN,
  output wire [`NUM_FPGA-1:0]   selected,
  output wire                   anySelected,
  output wire                   selectedDone
);

  localparam integer PULSE_FULL = `ERASE_PULSE_CYC;
  localparam [3:0]   PULSE_CYC  = PULSE_FULL[3:0];

  genvar i;
  generate
    for (i = 0; i < `NUM_FPGA; i = i + 1)
    begin : chan
      reg [3:0] pulseCount;
      reg       sel;
      wire      hitErase  = (eraseStrobe && eraseIndex == i) || (selectStrobe && selectIndex == i);
      always @(posedge clk)
      begin
        if (reset)
        begin
          pulseCount <= 4'h0;
          sel        <= 1'b0;
        end
        else
        begin
          if (hitErase)
            pulseCount <= PULSE_CYC;
          else if (pulseCount != 4'h0)
            pulseCount <= pulseCount - 4'h1;
          if (releaseAll)
            sel <= 1'b0;
          else if (selectStrobe)
            sel <= (selectIndex == i);
        end
      end
      assign progN[i]    = (pulseCount == 4'h0);
      assign selected[i] = sel;
    end
  endgenerate

  assign anySelected  = |selected;
  assign selectedDone = |(selected & configDone);

endmodule

// file: verilog/usb_vendor_regs.vh
`ifndef USB_VENDOR_REGS_VH
`define USB_VENDOR_REGS_VH

// Vendor request codes
`define CODE_FW_REV          8'ha6
`define CODE_MEDIA_LOAD      8'haf
`define CODE_FLASH_VER       8'hb2
`define CODE_CFG_STATE       8'hb5
`define CODE_BOARD_TYPE      8'hb9
`define CODE_ERASE           8'h90
`define CODE_TARGET_SELECT   8'hb7
`define CODE_TARGET_RELEASE  8'hbd
`define CODE_READ_LENGTH     8'hbb
`define CODE_REG_WRITE       8'hbe

// Setup packet fields
`define TYPE_DIR_BIT         7
`define TYPE_KIND_HI         6
`define TYPE_KIND_LO         5
`define TYPE_KIND_VENDOR     2'h2

// Configuration registers
`define ADDR_MAIN_BUS_DISABLE 16'hdf39
`define RST_MAIN_BUS_DISABLE  8'h00
`define MAIN_BUS_DISABLE_BIT  0

// Flash version location
`define FLASH_VER_UPPER      8'h08
`define FLASH_VER_LOWER      8'h00

// Configured-state answer characters
`define CHAR_CONFIGURED      8'h59
`define CHAR_BLANK           8'h4e

// Device count
`define NUM_FPGA             16
`define FPGA_IDX_W           4

// Timing
`define CLK_PERIOD_NS        50
`define ERASE_PULSE_NS       500
`define ERASE_PULSE_CYC      ((`ERASE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: verilog/usb_vendor_request_decoder.v
// Functional notes
// - Only vendor requests and bulk transfers serviced
// - Code 0xA6 returns firmware revision
// - Code 0xAF starts media card load
// - Code 0xB2 reads and returns flash version
// - Code 0xB5 reports selected FPGA configured
// - Code 0xB9 returns board type byte
// - Code 0x90 erases FPGA from value
// - Code 0xB7 selects FPGA from data byte
// - Selecting an FPGA also erases it
// - Code 0xBD deselects all, returns done on IN requests
// - Code 0xBB latches next bulk read length
// - Code 0xBE writes one byte to register
// - Configuration registers are one byte wide
// - Register 0xDF39 disables main bus
// - Flash version uses upper address 0x08
// - Bulk transfers carry configuration and main bus
// - Selected FPGA takes bulk data as configuration
`timescale 1ns/1ps
`include "usb_vendor_regs.vh"

module usb_vendor_request_decoder
#(
  // Arbitrary identification values
  parameter [7:0] FW_REVISION = 8'h01,
  parameter [7:0] BOARD_TYPE  = 8'h01
)
(
  // Clock and reset
  input  wire                   clk,
  input  wire                   reset,
  // Setup packet
  input  wire                   setupValid,
  output wire                   setupReady,
  input  wire [7:0]             setupType,
  input  wire [7:0]             setupCode,
  input  wire [15:0]            setupValue,
  input  wire [15:0]            setupLength,
  // OUT data stage
  input  wire                   outValid,
  output wire                   outReady,
  input  wire [7:0]             outData,
  // Request answer
  output reg                    inValid,
  output reg  [7:0]             inData,
  output reg                    reqDone,
  output reg                    reqStall,
  // Flash read port
  output reg                    flashReq,
  output reg  [15:0]            flashAddr,
  input  wire                   flashAck,
  input  wire [7:0]             flashData,
  // Media card loader
  output reg                    mediaLoadStart,
  // Configuration register write port
  output reg                    regWrite,
  output reg  [15:0]            regAddr,
  output reg  [7:0]             regData,
  output reg  [7:0]             mainBusDisable,
  // Bulk write stream
  input  wire                   bulkValid,
  input  wire [7:0]             bulkData,
  output reg                    cfgStrobe,
  output reg  [7:0]             cfgData,
  output reg                    mainBusStrobe,
  output reg  [7:0]             mainBusData,
  output reg  [15:0]            readLength,
  // FPGA control
  input  wire [`NUM_FPGA-1:0]   configDone,
  output wire [`NUM_FPGA-1:0]   progN,
  output wire [`NUM_FPGA-1:0]   selected
);

  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_DATA   = 3'h1;
  localparam [2:0] ST_FLASH  = 3'h2;
  localparam [2:0] ST_ANSWER = 3'h3;
  localparam [2:0] ST_ACK    = 3'h4;
  localparam [2:0] ST_STALL  = 3'h5;

  localparam [15:0] LEN_ZERO = 16'h0000;
  localparam [15:0] LEN_ONE  = 16'h0001;
  localparam integer NUM_DEV   = `NUM_FPGA;
  localparam [7:0]  IDX_LIMIT = NUM_DEV[7:0];

  reg  [2:0]             state;
  reg  [7:0]             code;
  reg  [7:0]             answer;
  reg                    eraseStrobe;
  reg  [`FPGA_IDX_W-1:0] eraseIndex;
  reg                    selectStrobe;
  reg  [`FPGA_IDX_W-1:0] selectIndex;
  reg                    releaseAll;
  wire                   anySelected;
  wire                   selectedDone;

  wire isVendor  = (setupType[`TYPE_KIND_HI:`TYPE_KIND_LO] == `TYPE_KIND_VENDOR);
  wire dirIn     = setupType[`TYPE_DIR_BIT];
  wire inOk      = dirIn && (setupLength != LEN_ZERO);
  wire outNoData = !dirIn && (setupLength == LEN_ZERO);
  wire outOneByte = !dirIn && (setupLength == LEN_ONE);
  wire valueIdxOk = (setupValue < {8'h00, IDX_LIMIT});

  assign setupReady = (state == ST_IDLE);
  assign outReady   = (state == ST_DATA);

  fpga_channel_ctrl channels
  (
    .clk          (clk),
    .reset        (reset),
    .eraseStrobe  (eraseStrobe),
    .eraseIndex   (eraseIndex),
    .selectStrobe (selectStrobe),
    .selectIndex  (selectIndex),
    .releaseAll   (releaseAll),
    .configDone   (configDone),
    .progN        (progN),
    .selected     (selected),
    .anySelected  (anySelected),
    .selectedDone (selectedDone)
  );

  // Request sequencer
  always @(posedge clk)
  begin
    if (reset)
    begin
      state          <= ST_IDLE;
      code           <= 8'h00;
      answer         <= 8'h00;
      inValid        <= 1'b0;
      inData         <= 8'h00;
      reqDone        <= 1'b0;
      reqStall       <= 1'b0;
      flashReq       <= 1'b0;
      flashAddr      <= 16'h0000;
      mediaLoadStart <= 1'b0;
      regWrite       <= 1'b0;
      regAddr        <= 16'h0000;
      regData        <= 8'h00;
      mainBusDisable <= `RST_MAIN_BUS_DISABLE;
      readLength     <= 16'h0000;
      eraseStrobe    <= 1'b0;
      eraseIndex     <= {`FPGA_IDX_W{1'b0}};
      selectStrobe   <= 1'b0;
      selectIndex    <= {`FPGA_IDX_W{1'b0}};
      releaseAll     <= 1'b0;
    end
    else
    begin
      inValid        <= 1'b0;
      reqDone        <= 1'b0;
      reqStall       <= 1'b0;
      flashReq       <= 1'b0;
      mediaLoadStart <= 1'b0;
      regWrite       <= 1'b0;
      eraseStrobe    <= 1'b0;
      selectStrobe   <= 1'b0;
      releaseAll     <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (setupValid)
          begin
            code    <= setupCode;
            regAddr <= setupValue;
            if (!isVendor)
              state <= ST_STALL;
            else
            begin
              case (setupCode)
                `CODE_FW_REV:
                begin
                  answer <= FW_REVISION;
                  state  <= inOk ? ST_ANSWER : ST_STALL;
                end
                `CODE_MEDIA_LOAD:
                begin
                  mediaLoadStart <= 1'b1;
                  state          <= ST_ACK;
                end
                `CODE_FLASH_VER:
                begin
                  if (inOk)
                  begin
                    flashAddr <= {`FLASH_VER_UPPER, `FLASH_VER_LOWER};
                    flashReq  <= 1'b1;
                    state     <= ST_FLASH;
                  end
                  else
                    state <= ST_STALL;
                end
                `CODE_CFG_STATE:
                begin
                  answer <= selectedDone ? `CHAR_CONFIGURED : `CHAR_BLANK;
                  state  <= inOk ? ST_ANSWER : ST_STALL;
                end
                `CODE_BOARD_TYPE:
                begin
                  answer <= BOARD_TYPE;
                  state  <= inOk ? ST_ANSWER : ST_STALL;
                end
                `CODE_ERASE:
                begin
                  if (outNoData && valueIdxOk)
                  begin
                    eraseStrobe <= 1'b1;
                    eraseIndex  <= setupValue[`FPGA_IDX_W-1:0];
                    state       <= ST_ACK;
                  end
                  else
                    state <= ST_STALL;
                end
                `CODE_TARGET_SELECT,
                `CODE_REG_WRITE:
                  state <= outOneByte ? ST_DATA : ST_STALL;
                `CODE_TARGET_RELEASE:
                begin
                  answer     <= {7'h00, selectedDone};
                  releaseAll <= 1'b1;
                  state      <= dirIn ? ST_ANSWER : ST_ACK;
                end
                `CODE_READ_LENGTH:
                begin
                  if (outNoData)
                  begin
                    readLength <= setupValue;
                    state      <= ST_ACK;
                  end
                  else
                    state <= ST_STALL;
                end
                default:
                  state <= ST_STALL;
              endcase
            end
          end
        end
        ST_DATA:
        begin
          if (outValid)
          begin
            if (code == `CODE_TARGET_SELECT)
            begin
              if (outData < IDX_LIMIT)
              begin
                selectStrobe <= 1'b1;
                selectIndex  <= outData[`FPGA_IDX_W-1:0];
                state        <= ST_ACK;
              end
              else
                state <= ST_STALL;
            end
            else
            begin
              regWrite <= 1'b1;
              regData  <= outData;
              if (regAddr == `ADDR_MAIN_BUS_DISABLE)
                mainBusDisable <= outData;
              state <= ST_ACK;
            end
          end
        end
        ST_FLASH:
        begin
          if (flashAck)
          begin
            answer <= flashData;
            state  <= ST_ANSWER;
          end
        end
        ST_ANSWER:
        begin
          inValid <= 1'b1;
          inData  <= answer;
          reqDone <= 1'b1;
          state   <= ST_IDLE;
        end
        ST_ACK:
        begin
          reqDone <= 1'b1;
          state   <= ST_IDLE;
        end
        ST_STALL:
        begin
          reqStall <= 1'b1;
          state    <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Bulk write routing
  always @(posedge clk)
  begin
    if (reset)
    begin
      cfgStrobe     <= 1'b0;
      cfgData       <= 8'h00;
      mainBusStrobe <= 1'b0;
      mainBusData   <= 8'h00;
    end
    else
    begin
      // bulk carries configuration and main bus
      cfgStrobe     <= bulkValid && anySelected;
      mainBusStrobe <= bulkValid && !anySelected && !mainBusDisable[`MAIN_BUS_DISABLE_BIT];
      if (bulkValid)
      begin
        cfgData     <= bulkData;
        mainBusData <= bulkData;
      end
    end
  end

endmodule
